// [sspk_defs.svh]
// Constants of the safety status word packer
`ifndef SSPK_DEFS_SVH
`define SSPK_DEFS_SVH
`define SSPK_ADR_CTRL 8'h00
`define SSPK_ADR_FUNC 8'h04
`define SSPK_ADR_STAT 8'h08
`define SSPK_ADR_POS 8'h0c
`define SSPK_ADR_IRQ_STAT 8'h10
`define SSPK_ADR_IRQ_CLR 8'h14
`define SSPK_ADR_IRQ_EN 8'h18
`define SSPK_ADR_INPUTS 8'h1c
`define SSPK_BIT_FAULT 7
`define SSPK_BIT_LS0 8
`define SSPK_BIT_STOP1 12
`define SSPK_BIT_STOP2 13
`define SSPK_BIT_SPARE 14
`define SSPK_BIT_ACK_ECHO 15
`define SSPK_CW_ACK_BIT 7
`define SSPK_POS_LSB 10
`define SSPK_POS_MSB 26
`define SSPK_POS_STEP_NM 102400
`define SSPK_POS_RANGE_NM 64'd6710886400
`define SSPK_FAULT_RST 1'b1
`define SSPK_CTRL_RST 16'h0080
`define SSPK_STATUS_RST 16'h0080
`define SSPK_IRQ_EN_RST 8'h00
`define SSPK_FUNC_RST 8'h00
`endif

// [sspk_pkg.sv]
// Types of the safety status word packer
package sspk_pkg;
  typedef enum logic [1:0] {
    SSPK_IDLE = 2'b00,
    SSPK_ACK = 2'b01
  } sspk_bus_st_t;
  typedef logic [15:0] sspk_word_t;
  typedef struct packed {
    logic stop_two;
    logic stop_one;
    logic [3:0] limited_speed;
  } sspk_func_t;
endpackage

// [sspk_in_if.sv]
// Synchronised safe input channels between modules
`timescale 1ns/1ps
interface sspk_in_if #(parameter int N = 4);
  logic [N-1:0] raw;
  logic [N-1:0] level;
  logic [N-1:0] change;
  modport filt(input raw, output level, output change);
  modport user(output raw, input level, input change);
endinterface

// [sspk_sync.sv]
// Three-stage synchroniser for safe input channels
`timescale 1ns/1ps
module sspk_sync #(
  parameter int N = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  sspk_in_if.filt io
);
  logic [N-1:0] s1_ff;
  logic [N-1:0] s2_ff;
  logic [N-1:0] s3_ff;
  logic [N-1:0] lvl_ff;
  logic [N-1:0] chg_ff;
  wire [N-1:0] agree = ~(s2_ff ^ s3_ff);
  wire [N-1:0] nxt_lvl = (agree & s3_ff) | (~agree & lvl_ff);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      lvl_ff <= '0;
      chg_ff <= '0;
    end else begin
      s1_ff <= io.raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
      chg_ff <= nxt_lvl ^ lvl_ff;
    end
  end
  assign io.level = lvl_ff;
  assign io.change = chg_ff;
endmodule

// [sspk_ack.sv]
// Fault acknowledge edge detector and status echo
`timescale 1ns/1ps
`include "sspk_defs.svh"
module sspk_ack (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ack_req,
  output logic ack_echo,
  output logic ack_fall
);
  logic req_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_ff <= 1'b1;
    end else begin
      req_ff <= ack_req;
    end
  end
  assign ack_fall = req_ff & ~ack_req;
  assign ack_echo = req_ff;
endmodule

// [sspk_top.sv]
// Safety status word packer with Wishbone register access
//
// Behaviour
// - Bit 8 clears whenever speed limit zero is inactive.
// - Bit 9 follows speed limit one like bit 8.
// - Bit 10 follows speed limit two like bit 8.
// - Bit 11 follows speed limit three like bit 8.
// - Bit 12 shows controlled stop then torque off is active.
// - Bit 13 shows controlled stop then hold is active.
// - Bit 15 echoes processed fault acknowledge request bit 7.
// - Transmitted position is sixteen bits of safe position from bit 10.
// - One step of transmitted position is 0.1024 mm.
// - Two safe inputs, each sampled as channels A and B.
// - Bit 8 set while speed limit zero is active from any demand.
// - Falling edge on control bit 7 acknowledges the group fault.
// - Fault bit 7 is set at startup until acknowledged.
`timescale 1ns/1ps
`include "sspk_defs.svh"
module sspk_top
  import sspk_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic WB_WE_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic WB_ERR_O,
  input wire logic [31:0] SAFE_POS_I,
  input wire logic [3:0] LIMITED_SPEED_ACTIVE_I,
  input wire logic STOP_ONE_ACTIVE_I,
  input wire logic STOP_TWO_ACTIVE_I,
  input wire logic FAULT_PRESENT_I,
  input wire logic SAFE_INPUT_1_CHAN_A,
  input wire logic SAFE_INPUT_1_CHAN_B,
  input wire logic SAFE_INPUT_2_CHAN_A,
  input wire logic SAFE_INPUT_2_CHAN_B,
  output logic [15:0] STATUS_WORD,
  output logic [15:0] TX_POS,
  output logic FAULT_ACK_PULSE,
  output logic IRQ
);
  localparam int POS_W = `SSPK_POS_MSB - `SSPK_POS_LSB;
  if (POS_W != 16) begin
    $error("Position slice must be sixteen bits");
  end

  // Bus state
  sspk_bus_st_t st_ff;
  sspk_bus_st_t nxt_st;
  logic [31:0] rdat_ff;
  logic err_ff;
  logic [15:0] ctrl_ff;
  sspk_func_t func_ff;
  logic fault_ff;
  logic [7:0] irq_stat_ff;
  logic [7:0] irq_en_ff;
  sspk_word_t status_ff;
  logic [15:0] pos_ff;
  logic [3:0] in_prev_ff;

  // Safe inputs, two channels each
  sspk_in_if #(.N(4)) in_if();
  assign in_if.raw = {SAFE_INPUT_2_CHAN_B, SAFE_INPUT_2_CHAN_A,
                      SAFE_INPUT_1_CHAN_B, SAFE_INPUT_1_CHAN_A};
  sspk_sync #(.N(4)) u_sync (
    .clk(MCLK),
    .rst_n(RST_N),
    .io(in_if.filt)
  );

  wire ack_echo;
  wire ack_fall;
  sspk_ack u_ack (
    .clk(MCLK),
    .rst_n(RST_N),
    .ack_req(ctrl_ff[`SSPK_CW_ACK_BIT]),
    .ack_echo(ack_echo),
    .ack_fall(ack_fall)
  );

  // Bus decode
  wire req = WB_CYC_I & WB_STB_I & (st_ff == SSPK_IDLE);
  wire wr = req & WB_WE_I;
  wire a_ctrl = WB_ADR_I == `SSPK_ADR_CTRL;
  wire a_func = WB_ADR_I == `SSPK_ADR_FUNC;
  wire a_stat = WB_ADR_I == `SSPK_ADR_STAT;
  wire a_pos = WB_ADR_I == `SSPK_ADR_POS;
  wire a_istat = WB_ADR_I == `SSPK_ADR_IRQ_STAT;
  wire a_iclr = WB_ADR_I == `SSPK_ADR_IRQ_CLR;
  wire a_ien = WB_ADR_I == `SSPK_ADR_IRQ_EN;
  wire a_in = WB_ADR_I == `SSPK_ADR_INPUTS;
  wire mapped = a_ctrl | a_func | a_stat | a_pos | a_istat | a_iclr |
                a_ien | a_in;
  wire [15:0] ctrl_wm = {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  wire [15:0] nxt_ctrl = (wr & a_ctrl) ?
                         ((ctrl_ff & ~ctrl_wm) | (WB_DAT_I[15:0] & ctrl_wm))
                         : ctrl_ff;
  wire func_we = wr & a_func & WB_SEL_I[0];
  wire [5:0] nxt_func = func_we ? WB_DAT_I[5:0] : func_ff;
  wire iclr_we = wr & a_iclr & WB_SEL_I[0];
  wire ien_we = wr & a_ien & WB_SEL_I[0];

  // Safety functions: process demand or software demand
  wire [3:0] ls_act = LIMITED_SPEED_ACTIVE_I | func_ff.limited_speed;
  wire stop1_act = STOP_ONE_ACTIVE_I | func_ff.stop_one;
  wire stop2_act = STOP_TWO_ACTIVE_I | func_ff.stop_two;
  // Fault stays set until acknowledged; new fault wins
  wire nxt_fault = FAULT_PRESENT_I | (fault_ff & ~ack_fall);

  sspk_word_t nxt_status;
  always_comb begin
    nxt_status = '0;
    nxt_status[`SSPK_BIT_FAULT] = fault_ff;
    for (int i = 0; i < 4; i++) begin
      nxt_status[`SSPK_BIT_LS0 + i] = ls_act[i];
    end
    nxt_status[`SSPK_BIT_STOP1] = stop1_act;
    nxt_status[`SSPK_BIT_STOP2] = stop2_act;
    nxt_status[`SSPK_BIT_SPARE] = 1'b0;
    nxt_status[`SSPK_BIT_ACK_ECHO] = ack_echo;
  end

  // Slice of safe position; LSB weight 0.1024 mm
  wire [15:0] nxt_pos = SAFE_POS_I[`SSPK_POS_LSB +: 16];

  // Events: fault set, acknowledge, stop activations, input changes
  wire [7:0] ev;
  assign ev[0] = nxt_fault & ~fault_ff;
  assign ev[1] = ack_fall;
  assign ev[2] = stop1_act & ~status_ff[`SSPK_BIT_STOP1];
  assign ev[3] = stop2_act & ~status_ff[`SSPK_BIT_STOP2];
  assign ev[7:4] = in_if.change;
  wire [7:0] clr_m = iclr_we ? WB_DAT_I[7:0] : 8'h00;
  wire [7:0] nxt_istat = ev | (irq_stat_ff & ~clr_m);
  wire [7:0] nxt_ien = ien_we ? WB_DAT_I[7:0] : irq_en_ff;

  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    if (a_ctrl) begin
      rmux = {16'h0000, ctrl_ff};
    end else if (a_func) begin
      rmux = {26'h000_0000, func_ff};
    end else if (a_stat) begin
      rmux = {16'h0000, status_ff};
    end else if (a_pos) begin
      rmux = {16'h0000, pos_ff};
    end else if (a_istat) begin
      rmux = {24'h00_0000, irq_stat_ff};
    end else if (a_ien) begin
      rmux = {24'h00_0000, irq_en_ff};
    end else if (a_in) begin
      rmux = {28'h000_0000, in_if.level};
    end
  end

  always_comb begin
    case (st_ff)
      SSPK_IDLE: nxt_st = req ? SSPK_ACK : SSPK_IDLE;
      SSPK_ACK: nxt_st = SSPK_IDLE;
      default: nxt_st = SSPK_IDLE;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      st_ff <= SSPK_IDLE;
      rdat_ff <= 32'h0000_0000;
      err_ff <= 1'b0;
      ctrl_ff <= `SSPK_CTRL_RST;
      func_ff <= '0;
      fault_ff <= `SSPK_FAULT_RST;
      irq_stat_ff <= 8'h00;
      irq_en_ff <= `SSPK_IRQ_EN_RST;
      status_ff <= `SSPK_STATUS_RST;
      pos_ff <= 16'h0000;
    end else begin
      st_ff <= nxt_st;
      if (req) begin
        rdat_ff <= WB_WE_I ? 32'h0000_0000 : rmux;
        err_ff <= ~mapped;
      end
      ctrl_ff <= nxt_ctrl;
      func_ff <= nxt_func;
      fault_ff <= nxt_fault;
      irq_stat_ff <= nxt_istat;
      irq_en_ff <= nxt_ien;
      status_ff <= nxt_status;
      pos_ff <= nxt_pos;
    end
  end

  assign WB_ACK_O = (st_ff == SSPK_ACK) & ~err_ff;
  assign WB_ERR_O = (st_ff == SSPK_ACK) & err_ff;
  assign WB_DAT_O = rdat_ff;
  assign STATUS_WORD = status_ff;
  assign TX_POS = pos_ff;
  assign FAULT_ACK_PULSE = ack_fall;
  assign IRQ = |(irq_stat_ff & irq_en_ff);
endmodule

// [sspk_props.sv]
// Port checker of the status word packer
`timescale 1ns/1ps
module sspk_props (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic WB_ERR_O,
  input wire logic [31:0] SAFE_POS_I,
  input wire logic [3:0] LIMITED_SPEED_ACTIVE_I,
  input wire logic STOP_ONE_ACTIVE_I,
  input wire logic STOP_TWO_ACTIVE_I,
  input wire logic FAULT_PRESENT_I,
  input wire logic [15:0] STATUS_WORD,
  input wire logic [15:0] TX_POS,
  input wire logic FAULT_ACK_PULSE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_ack_clean;
    FAULT_ACK_PULSE ##0 (!FAULT_PRESENT_I)[*3];
  endsequence
  property p_ls0; LIMITED_SPEED_ACTIVE_I[0] |=> STATUS_WORD[8]; endproperty
  property p_ls_hi;
    1'b1 |=> (STATUS_WORD[11:9] & $past(LIMITED_SPEED_ACTIVE_I[3:1]))
      == $past(LIMITED_SPEED_ACTIVE_I[3:1]);
  endproperty
  property p_stop1; STOP_ONE_ACTIVE_I |=> STATUS_WORD[12]; endproperty
  property p_stop2; STOP_TWO_ACTIVE_I |=> STATUS_WORD[13]; endproperty
  // Fault goes through its own flag before the status word
  property p_fault; FAULT_PRESENT_I |-> ##2 STATUS_WORD[7]; endproperty
  property p_spare; STATUS_WORD[14] == 1'b0; endproperty
  property p_pos; 1'b1 |=> TX_POS == $past(SAFE_POS_I[25:10]); endproperty
  property p_clear; s_ack_clean |-> ##[0:1] !STATUS_WORD[7]; endproperty
  property p_echo; FAULT_ACK_PULSE |-> ##[0:2] !STATUS_WORD[15]; endproperty
  property p_wb; $rose(WB_STB_I) |=> WB_ACK_O ^ WB_ERR_O; endproperty
  a_ls0: assert property (p_ls0) else $error("speed 0 bit");
  a_ls_hi: assert property (p_ls_hi) else $error("speed bits");
  a_stop1: assert property (p_stop1) else $error("stop one");
  a_stop2: assert property (p_stop2) else $error("stop two");
  a_fault: assert property (p_fault) else $error("fault bit");
  a_spare: assert property (p_spare) else $error("bit 14");
  a_pos: assert property (p_pos) else $error("position");
  a_clear: assert property (p_clear) else $error("fault ack");
  a_echo: assert property (p_echo) else $error("ack echo");
  a_wb: assert property (p_wb) else $error("bus answer");
endmodule

// [sspk_plc.sv]
// Safety controller model driving the safe input channels
`timescale 1ns/1ps
module sspk_plc (
  input wire logic clk,
  input wire logic [1:0] demand,
  output logic [3:0] chan
);
  // Both channels of each input driven from the same demand bit, a shorted pair
  always_ff @(posedge clk) begin
    chan[1:0] <= {2{demand[0]}};
    chan[3:2] <= {2{demand[1]}};
  end
endmodule

// [sspk_tb.sv]
// Self-checking bench of the status word packer
`timescale 1ns/1ps
`include "sspk_defs.svh"
module testbench;
  logic clk, rst_n, cyc, stb, we, ack, err, s1, s2, fp, pulse, irq, e;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, pos, q;
  logic [3:0] sel, ls, chan;
  logic [15:0] sw, txp;
  logic [1:0] dem;
  int err_total = 0;
  int n_compared = 0;
  sspk_top uut (.MCLK(clk), .RST_N(rst_n), .WB_ADR_I(adr), .WB_DAT_I(wdat),
    .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .WB_ERR_O(err), .SAFE_POS_I(pos),
    .LIMITED_SPEED_ACTIVE_I(ls), .STOP_ONE_ACTIVE_I(s1),
    .STOP_TWO_ACTIVE_I(s2), .FAULT_PRESENT_I(fp),
    .SAFE_INPUT_1_CHAN_A(chan[0]), .SAFE_INPUT_1_CHAN_B(chan[1]),
    .SAFE_INPUT_2_CHAN_A(chan[2]), .SAFE_INPUT_2_CHAN_B(chan[3]),
    .STATUS_WORD(sw), .TX_POS(txp), .FAULT_ACK_PULSE(pulse), .IRQ(irq));
  sspk_plc u_plc (.clk(clk), .demand(dem), .chan(chan));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task end_of_test;
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    if (n == 20) begin
      err_total++;
      end_of_test();
    end
    q = rdat;
    e = err;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    wb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  initial begin
    rst_n = 0; cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0; sel = 4'hf;
    pos = 0; ls = 0; s1 = 0; s2 = 0; fp = 0; dem = 0;
    cy(3);
    rst_n <= 1'b1;
    chk(32'(sw), 32'h0080);
    cy(3);
    rd(`SSPK_ADR_STAT, 32'h8080);
    rd(`SSPK_ADR_IRQ_EN, 32'h0);
    wb(1'b1, `SSPK_ADR_CTRL, 32'h0);
    chk(32'(pulse), 32'h1);
    cy(3);
    chk(32'(sw), 32'h0);
    wb(1'b1, `SSPK_ADR_CTRL, 32'h80);
    fp <= 1'b1;
    wb(1'b1, `SSPK_ADR_CTRL, 32'h0);
    cy(2);
    chk(32'(sw), 32'h0080);
    fp <= 1'b0;
    wb(1'b1, `SSPK_ADR_CTRL, 32'h80);
    wb(1'b1, `SSPK_ADR_STAT, 32'hffff);
    rd(`SSPK_ADR_STAT, 32'h8080);
    wb(1'b1, `SSPK_ADR_CTRL, 32'h0);
    wb(1'b1, `SSPK_ADR_CTRL, 32'h80);
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, `SSPK_ADR_FUNC, 32'h1 << i);
      rd(`SSPK_ADR_STAT, 32'h8000 | (32'h100 << i));
      {s2, s1, ls} <= 6'h1 << i;
      wb(1'b1, `SSPK_ADR_FUNC, 32'h0);
      cy(2);
      chk(32'(sw), 32'h8000 | (32'h100 << i));
      {s2, s1, ls} <= 6'h0;
      cy(2);
      chk(32'(sw), 32'h8000);
    end
    pos <= 32'h0000_0400;
    cy(2);
    chk(32'(txp), 32'h1);
    pos <= 32'hf800_03ff;
    cy(2);
    chk(32'(txp), 32'h0);
    pos <= 32'h07ff_fc00;
    rd(`SSPK_ADR_POS, 32'hffff);
    wb(1'b0, 8'h20, 32'h0);
    chk(32'(e), 32'h1);
    rd(`SSPK_ADR_IRQ_STAT, 32'h0f);
    wb(1'b1, `SSPK_ADR_IRQ_CLR, 32'hff);
    wb(1'b1, `SSPK_ADR_IRQ_EN, 32'h04);
    s1 <= 1'b1;
    cy(3);
    chk(32'(irq), 32'h1);
    s1 <= 1'b0;
    rd(`SSPK_ADR_IRQ_STAT, 32'h04);
    wb(1'b1, `SSPK_ADR_IRQ_EN, 32'h0);
    chk(32'(irq), 32'h0);
    wb(1'b1, `SSPK_ADR_IRQ_EN, 32'h04);
    chk(32'(irq), 32'h1);
    wb(1'b1, `SSPK_ADR_IRQ_CLR, 32'h04);
    chk(32'(irq), 32'h0);
    dem <= 2'b01;
    cy(6);
    rd(`SSPK_ADR_INPUTS, 32'h3);
    dem <= 2'b10;
    cy(6);
    rd(`SSPK_ADR_INPUTS, 32'hc);
    rd(`SSPK_ADR_IRQ_STAT, 32'hf0);
    rst_n <= 1'b0;
    cy(3);
    rst_n <= 1'b1;
    chk(32'(sw), 32'h0080);
    cy(2);
    chk(32'(sw), 32'h8080);
    end_of_test();
  end
endmodule
bind sspk_top sspk_props u_props (.MCLK, .RST_N, .WB_STB_I, .WB_ACK_O,
  .WB_ERR_O, .SAFE_POS_I, .LIMITED_SPEED_ACTIVE_I, .STOP_ONE_ACTIVE_I,
  .STOP_TWO_ACTIVE_I, .FAULT_PRESENT_I, .STATUS_WORD, .TX_POS,
  .FAULT_ACK_PULSE);
